//--- core/uls_pkg.sv
// Package for the line-status logic: register map, fields, entry layout
package uls_pkg;

    // Register byte offsets (low address byte)
    localparam logic [7:0] ULS_OFF_RXBUF = 8'h00;
    localparam logic [7:0] ULS_OFF_LSR   = 8'h04;
    localparam logic [7:0] ULS_OFF_CTL   = 8'h08;

    // Line status bit positions
    localparam int ULS_LSR_RDY  = 0;
    localparam int ULS_LSR_OE   = 1;
    localparam int ULS_LSR_PAR  = 2;
    localparam int ULS_LSR_FRM  = 3;
    localparam int ULS_LSR_BRK  = 4;
    localparam int ULS_LSR_HOLD = 5;
    localparam int ULS_LSR_TXE  = 6;
    localparam int ULS_LSR_ERR  = 7;

    // Control bit positions
    localparam int ULS_CTL_FIFO = 0;
    localparam int ULS_CTL_FMT  = 1;
    localparam int ULS_CTL_PAR  = 4;
    localparam int ULS_CTL_BRK  = 5;

    // Reset values
    localparam logic [7:0] ULS_CTL_RST = 8'h00;
    localparam logic [7:0] ULS_LSR_RST = 8'h60;

    // Receive FIFO geometry
    localparam int ULS_DEPTH = 16;
    localparam int ULS_AW    = 4;

    // Bus responses
    localparam logic [1:0] ULS_OKAY   = 2'h0;
    localparam logic [1:0] ULS_SLVERR = 2'h2;

    // One received character with its error tags
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } uls_entry_s;

    // Transmitter state seen by the status logic
    typedef struct packed {
        logic hold_empty;
        logic shift_empty;
        logic idle;
    } uls_tx_s;

    // Bit times in one character: start, data, parity, stop
    function automatic logic [3:0] uls_char_ticks(input logic [2:0] fmt,
                                                  input logic       par);
        uls_char_ticks = 4'h7 + {2'h0, fmt[1:0]} + {3'h0, par} + {3'h0, fmt[2]};
    endfunction : uls_char_ticks

endpackage : uls_pkg

//--- core/uls_brk_det.sv
// Break detector: receive line low for longer than one character time
`timescale 1ns/1ps
`default_nettype none
module uls_brk_det
    import uls_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Line and timing
    input  wire logic       rx_low,
    input  wire logic       baud_tick,
    input  wire logic [3:0] char_ticks,
    // Event
    output logic            brk_pulse
);
    logic [3:0] cnt_reg;
    logic       done_reg;

    // Count bit times while low; one event per low stretch
    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_low) begin
            cnt_reg  <= 4'h0;
            done_reg <= 1'b0;
        end else if (baud_tick && !done_reg) begin
            if (cnt_reg == char_ticks) begin
                done_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    // Fires on the tick past a full character time
    assign brk_pulse = rx_low && baud_tick && !done_reg && (cnt_reg == char_ticks);

endmodule : uls_brk_det
`default_nettype wire

//--- core/uls_rx_fifo.sv
// Receive FIFO with a count of entries that carry an error tag
`timescale 1ns/1ps
`default_nettype none
module uls_rx_fifo
    import uls_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             flush,
    // Fill side
    input  wire logic             push,
    input  wire uls_entry_s       push_data,
    // Drain side
    input  wire logic             pop,
    output uls_entry_s            head,
    // State
    output logic [ULS_AW:0]       count,
    output logic                  any_err
);
    uls_entry_s          mem_reg [ULS_DEPTH];
    logic [ULS_AW-1:0]   wr_reg;
    logic [ULS_AW-1:0]   rd_reg;
    logic [ULS_AW:0]     cnt_reg;
    logic [ULS_AW:0]     err_reg;
    logic                push_err;
    logic                pop_err;

    assign push_err = push && (push_data.brk || push_data.frm || push_data.par);
    assign pop_err  = pop && (head.brk || head.frm || head.par);

    // Storage; caller never pushes when full nor pops when empty
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_reg[wr_reg] <= push_data;
        end
    end

    // Pointers and counts
    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
            err_reg <= '0;
        end else begin
            wr_reg  <= wr_reg + ULS_AW'(push);
            rd_reg  <= rd_reg + ULS_AW'(pop);
            cnt_reg <= cnt_reg + (ULS_AW+1)'(push) - (ULS_AW+1)'(pop);
            err_reg <= err_reg + (ULS_AW+1)'(push_err) - (ULS_AW+1)'(pop_err);
        end
    end

    assign head    = mem_reg[rd_reg];
    assign count   = cnt_reg;
    assign any_err = (err_reg != '0);

endmodule : uls_rx_fifo
`default_nettype wire

//--- core/uls_line_status.sv
// Line-status logic of a serial port with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module uls_line_status
    import uls_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Receiver side
    input  wire logic        rxd_pin,
    input  wire logic        baud_tick,
    input  wire logic        rx_char_valid,
    input  wire uls_entry_s  rx_char,
    // Transmitter side
    input  wire uls_tx_s     tx_stat,
    output logic             tx_break,
    // Character format to the shift registers
    output logic             fifo_enable,
    output logic [2:0]       char_format,
    output logic             parity_enable
);
    // Bus state
    logic             aw_got_reg;
    logic             w_got_reg;
    logic [7:0]       awaddr_reg;
    logic [31:0]      wdata_reg;
    logic             wstrb0_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;
    logic             rvalid_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       rresp_reg;
    logic [7:0]       ctl_reg;
    // Receive state
    logic             rx_sync1_reg;
    logic             rx_sync2_reg;
    uls_entry_s       buf_reg;
    logic             buf_full_reg;
    logic             head_new_reg;
    logic             oe_reg;
    logic             parity_error_reg;
    logic             framing_error_reg;
    logic             break_indicator_reg;
    logic             err_reg;
    // Combinational
    logic             wr_fire;
    logic             ar_hs;
    logic             lsr_rd;
    logic             rbr_rd;
    logic             brk_pulse;
    logic             push_req;
    logic             push_ok;
    logic             pop;
    logic             flush;
    logic             fifo_full;
    logic             fifo_empty;
    logic             fifo_err;
    logic             head_new;
    logic [ULS_AW:0]  fifo_cnt;
    uls_entry_s       fifo_head;
    uls_entry_s       head;
    uls_entry_s       push_data;
    logic [7:0]       lsr;
    logic             tx_holding_empty;
    logic             transmitter_empty;
    logic             receive_data_ready;

    // Address check on the low byte, word aligned
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction : is_reg

    // Write channels taken independently, answered once both are in
    assign awready = !aw_got_reg && !bvalid_reg;
    assign wready  = !w_got_reg && !bvalid_reg;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (awvalid && awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= awaddr[7:0];
        end else if (wr_fire) begin
            aw_got_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_reg  <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
        end else if (wvalid && wready) begin
            w_got_reg  <= 1'b1;
            wdata_reg  <= wdata;
            wstrb0_reg <= wstrb[0];
        end else if (wr_fire) begin
            w_got_reg <= 1'b0;
        end
    end

    // Write response; status and buffer accept and drop writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= ULS_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            if (is_reg(awaddr_reg, ULS_OFF_CTL) || is_reg(awaddr_reg, ULS_OFF_LSR)
                || is_reg(awaddr_reg, ULS_OFF_RXBUF)) begin
                bresp_reg <= ULS_OKAY;
            end else begin
                bresp_reg <= ULS_SLVERR;
            end
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp  = bresp_reg;

    // Control register, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= ULS_CTL_RST;
        end else if (wr_fire && wstrb0_reg && is_reg(awaddr_reg, ULS_OFF_CTL)) begin
            ctl_reg <= {2'h0, wdata_reg[5:0]};
        end
    end

    assign fifo_enable   = ctl_reg[ULS_CTL_FIFO];
    assign char_format   = ctl_reg[ULS_CTL_FMT +: 3];
    assign parity_enable = ctl_reg[ULS_CTL_PAR];
    assign tx_break      = ctl_reg[ULS_CTL_BRK];
    // Switching the FIFO on or off discards queued characters
    assign flush = wr_fire && wstrb0_reg && is_reg(awaddr_reg, ULS_OFF_CTL)
                   && (wdata_reg[ULS_CTL_FIFO] != fifo_enable);

    // Read channel; side effects happen at the address handshake
    assign arready = !rvalid_reg;
    assign ar_hs   = arvalid && arready;
    assign lsr_rd  = ar_hs && is_reg(araddr[7:0], ULS_OFF_LSR);
    assign rbr_rd  = ar_hs && is_reg(araddr[7:0], ULS_OFF_RXBUF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= ULS_OKAY;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= ULS_OKAY;
            if (lsr_rd) begin
                rdata_reg <= {24'h00_0000, lsr};
            end else if (rbr_rd) begin
                rdata_reg <= {24'h00_0000, receive_data_ready ? head.data : 8'h00};
            end else if (is_reg(araddr[7:0], ULS_OFF_CTL)) begin
                rdata_reg <= {24'h00_0000, ctl_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= ULS_SLVERR;
            end
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata  = rdata_reg;
    assign rresp  = rresp_reg;

    // Receive pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sync1_reg <= 1'b1;
            rx_sync2_reg <= 1'b1;
        end else begin
            rx_sync1_reg <= rxd_pin;
            rx_sync2_reg <= rx_sync1_reg;
        end
    end

    uls_brk_det u_brk (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .rx_low     (!rx_sync2_reg),
        .baud_tick  (baud_tick),
        .char_ticks (uls_char_ticks(char_format, parity_enable)),
        .brk_pulse  (brk_pulse)
    );

    // In FIFO mode a break outranks a character completing in the same cycle
    always_comb begin
        push_data = rx_char;
        if (brk_pulse) begin
            push_data = '{brk: 1'b1, frm: 1'b1, par: 1'b0, data: 8'h00};
        end
    end

    assign push_req   = rx_char_valid || (brk_pulse && fifo_enable);
    assign fifo_full  = (fifo_cnt == (ULS_AW+1)'(ULS_DEPTH));
    assign fifo_empty = (fifo_cnt == '0);
    assign push_ok    = fifo_enable && push_req && !fifo_full;
    assign pop        = fifo_enable && rbr_rd && !fifo_empty;

    uls_rx_fifo u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flush     (flush),
        .push      (push_ok),
        .push_data (push_data),
        .pop       (pop),
        .head      (fifo_head),
        .count     (fifo_cnt),
        .any_err   (fifo_err)
    );

    // Single buffer used while the FIFO is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_reg      <= '0;
            buf_full_reg <= 1'b0;
        end else if (!fifo_enable && rx_char_valid) begin
            buf_reg      <= rx_char;
            buf_full_reg <= 1'b1;
        end else if (rbr_rd || fifo_enable) begin
            buf_full_reg <= 1'b0;
        end
    end

    assign head = fifo_enable ? fifo_head : buf_reg;
    // Data ready follows occupancy, so it drops with the last pop
    assign receive_data_ready = fifo_enable ? !fifo_empty : buf_full_reg;

    // A new character reaches the head; its tags are read a cycle later
    assign head_new = fifo_enable
        ? ((push_ok && (fifo_empty || (pop && fifo_cnt == (ULS_AW+1)'(1))))
           || (pop && fifo_cnt > (ULS_AW+1)'(1)))
        : rx_char_valid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_new_reg <= 1'b0;
        end else begin
            head_new_reg <= head_new;
        end
    end

    // Head error tags; a tag landing with a status read survives it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            framing_error_reg <= 1'b0;
            parity_error_reg  <= 1'b0;
        end else begin
            framing_error_reg <= (head_new_reg && head.frm)
                                 || (framing_error_reg && !lsr_rd);
            parity_error_reg  <= (head_new_reg && head.par)
                                 || (parity_error_reg && !lsr_rd);
        end
    end

    // Break indicator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            break_indicator_reg <= 1'b0;
        end else begin
            break_indicator_reg <= brk_pulse
                                   || (break_indicator_reg && !lsr_rd);
        end
    end

    // Overrun: unread buffer overwritten, or FIFO full and character dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_reg <= 1'b0;
        end else if (!fifo_enable && rx_char_valid && buf_full_reg && !rbr_rd) begin
            oe_reg <= 1'b1;
        end else if (fifo_enable && push_req && fifo_full) begin
            oe_reg <= 1'b1;
        end else if (lsr_rd) begin
            oe_reg <= 1'b0;
        end
    end

    // Error summary holds while errored entries remain
    always_ff @(posedge aclk) begin
        if (!aresetn || !fifo_enable) begin
            err_reg <= 1'b0;
        end else if (fifo_err) begin
            err_reg <= 1'b1;
        end else if (lsr_rd) begin
            err_reg <= 1'b0;
        end
    end

    // Transmit flags held low while a break is sent
    assign tx_holding_empty  = tx_stat.hold_empty && !tx_break;
    assign transmitter_empty = tx_holding_empty && tx_stat.shift_empty && tx_stat.idle;

    assign lsr = {err_reg && fifo_enable, transmitter_empty, tx_holding_empty,
                  break_indicator_reg, framing_error_reg, parity_error_reg, oe_reg,
                  receive_data_ready};

    // Checks
    txe_gate_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lsr[ULS_LSR_TXE] |-> tx_stat.hold_empty && tx_stat.shift_empty && tx_stat.idle)
        else $error("transmitter empty without idle transmitter");

    brk_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tx_break |-> !lsr[ULS_LSR_HOLD] && !lsr[ULS_LSR_TXE])
        else $error("empty flags set during break");

    hold_rd_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lsr_rd && !tx_break && tx_stat.hold_empty |=> rdata[ULS_LSR_HOLD])
        else $error("holding empty not reported");

    brk_set_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        brk_pulse |=> break_indicator_reg)
        else $error("break indicator not set");

    brk_push_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        brk_pulse && fifo_enable && !fifo_full && !pop && !flush
        |=> fifo_cnt == $past(fifo_cnt) + (ULS_AW+1)'(1))
        else $error("break character not queued");

    brk_clr_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lsr_rd && !brk_pulse |=> !break_indicator_reg)
        else $error("break indicator survived status read");

    // A new head one cycle after the read may legally set the flag again
    frm_clr_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lsr_rd && !head_new_reg
        |=> !framing_error_reg ##1 (!framing_error_reg || $past(head_new_reg)))
        else $error("framing error survived status read");

    oe_fifo_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fifo_enable && push_req && fifo_full && !pop && !flush
        |=> oe_reg && fifo_cnt == (ULS_AW+1)'(ULS_DEPTH))
        else $error("overrun missed or character stored");

    rdy_clr_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fifo_enable && pop && fifo_cnt == (ULS_AW+1)'(1) && !push_ok && !flush
        |=> !lsr[ULS_LSR_RDY])
        else $error("data ready stayed after last byte");

    err_off_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !fifo_enable |-> !lsr[ULS_LSR_ERR])
        else $error("error summary set with FIFO off");

    err_set_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fifo_enable && fifo_err && !flush |=> lsr[ULS_LSR_ERR])
        else $error("error summary missed an errored entry");

endmodule : uls_line_status
`default_nettype wire

//--- test/uls_remote_tx.sv
// Remote serial transmitter model facing the receive side of the status logic
`timescale 1ns/1ps
`default_nettype none
module uls_remote_tx
    import uls_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Toward the receiver
    output var logic       rxd_pin,
    output logic           baud_tick,
    output var logic       rx_char_valid,
    output var uls_entry_s rx_char
);
    logic [1:0] div_reg;

    // Line idles at mark level, no character offered
    initial begin
        rxd_pin       = 1'b1;
        rx_char_valid = 1'b0;
        rx_char       = '0;
    end

    // One bit time per four clocks keeps break stretches short
    always_ff @(posedge aclk) begin
        if (!aresetn)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    assign baud_tick = (div_reg == 2'h3);

    // One completed character; stop-bit and parity faults ride in the tags
    task automatic send(input uls_entry_s ch);
        @(posedge aclk);
        rx_char_valid <= 1'b1;
        rx_char       <= ch;
        @(posedge aclk);
        rx_char_valid <= 1'b0;
        rx_char       <= ~ch;  // Stale bus shows garbage, not the old character
    endtask : send

    // Line held low for exactly k bit times, dropped just after a tick
    task automatic brk(input int k);
        @(posedge aclk iff baud_tick);
        rxd_pin <= 1'b0;
        repeat (k) @(posedge aclk iff baud_tick);
        rxd_pin <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask : brk

endmodule : uls_remote_tx
`default_nettype wire

//--- test/test_uls_line_status.sv
// Self-checking bench for the line-status logic over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module test_uls_line_status
    import uls_pkg::*;
;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, rxd_pin, baud_tick, rx_char_valid;
    logic        tx_break, fifo_enable, parity_enable;
    logic [31:0] awaddr, wdata, araddr, rdata, rv;
    logic [3:0]  wstrb;
    logic [2:0]  char_format;
    logic [1:0]  bresp, rresp, rr;
    uls_entry_s  rx_char;
    uls_tx_s     tx_stat;
    int          fail_count, check_count, i, j;

    uls_line_status i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .rxd_pin, .baud_tick, .rx_char_valid, .rx_char,
        .tx_stat, .tx_break, .fifo_enable, .char_format, .parity_enable);
    uls_remote_tx i_peer (.aclk, .aresetn, .rxd_pin, .baud_tick, .rx_char_valid, .rx_char);

    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Address and data offered together, each dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t;
        @(posedge aclk);
        awaddr  <= {24'h0, a};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t  = wvalid && wready;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(negedge aclk); while (!bvalid);
        chk("bresp", {30'h0, bresp}, {30'h0, ULS_OKAY});
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    // Ready levels are settled at the falling edge, ahead of the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= {24'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        rv = rdata;
        rr = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    task automatic lsr(input logic [7:0] e);
        rd(ULS_OFF_LSR);
        chk("line_status", rv, {24'h0, e});
        chk("rresp", {30'h0, rr}, {30'h0, ULS_OKAY});
    endtask : lsr

    task automatic rbr(input logic [7:0] e);
        rd(ULS_OFF_RXBUF);
        chk("receive_buffer", rv, {24'h0, e});
    endtask : rbr

    task automatic snd(input logic f, input logic p, input logic [7:0] d);
        i_peer.send({1'b0, f, p, d});
        repeat (3) @(posedge aclk);
    endtask : snd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb   = 4'hF;
        tx_stat = 3'h7;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        lsr(8'h60);
        rd(8'h0C);
        chk("unmapped_resp", {30'h0, rr}, {30'h0, ULS_SLVERR});
        chk("unmapped_data", rv, 32'h0);
        // Every transmitter state combination
        for (i = 0; i < 8; i++) begin
            tx_stat <= i[2:0];
            rd(ULS_OFF_LSR);
            chk("tx_holding_empty", {31'h0, rv[ULS_LSR_HOLD]}, {31'h0, i[2]});
            chk("transmitter_empty", {31'h0, rv[ULS_LSR_TXE]}, {31'h0, i == 7});
        end
        wr(ULS_OFF_CTL, 32'h20);
        chk("tx_break", {31'h0, tx_break}, 32'h1);
        lsr(8'h00);
        wr(ULS_OFF_CTL, 32'h00);
        lsr(8'h60);
        wr(ULS_OFF_LSR, 32'hFF);
        lsr(8'h60);
        // Break command on a masked byte lane must not take effect
        wstrb <= 4'hE;
        wr(ULS_OFF_CTL, 32'h20);
        wstrb <= 4'hF;
        lsr(8'h60);
        // Single buffer: load, overwrite unread, errored character
        snd(1'b0, 1'b0, 8'h5A);
        lsr(8'h61);
        snd(1'b0, 1'b0, 8'hA5);
        lsr(8'h63);
        lsr(8'h61);
        rbr(8'hA5);
        lsr(8'h60);
        snd(1'b1, 1'b1, 8'h3C);
        lsr(8'h6D);
        lsr(8'h61);
        rbr(8'h3C);
        // Break of exactly one character, then one bit time beyond a character
        for (j = 0; j < 2; j++) begin
            wr(ULS_OFF_CTL, (j == 1) ? 32'h1E : 32'h00);
            i_peer.brk((j == 1) ? 12 : 7);
            lsr(8'h60);
            i_peer.brk((j == 1) ? 13 : 8);
            lsr(8'h70);
            lsr(8'h60);
        end
        chk("char_format", {28'h0, parity_enable, char_format}, 32'hF);
        rd(ULS_OFF_CTL);
        chk("control", rv, 32'h1E);
        // FIFO: break entry, fill past full, drain
        wr(ULS_OFF_CTL, 32'h01);
        chk("fifo_enable", {31'h0, fifo_enable}, 32'h1);
        i_peer.brk(8);
        lsr(8'hF9);
        rbr(8'h00);
        lsr(8'hE0);
        lsr(8'h60);
        for (i = 0; i < ULS_DEPTH + 1; i++) begin
            snd(1'b0, i == 3, i[7:0]);
            if (i == 0) lsr(8'h61);
        end
        lsr(8'hE3);
        for (i = 0; i < ULS_DEPTH; i++) begin
            rbr(i[7:0]);
            if (i == 2) lsr(8'hE5);
        end
        lsr(8'hE0);
        lsr(8'h60);
        print_verdict();
    end

endmodule : test_uls_line_status
`default_nettype wire
